// ### verilog/rtcs_cfg.svh
// constants for the ram transfer checksum block
// Behaviour
// - checksum accumulates every data byte the host writes while clk_en is high, except one written in the same cycle as a select bits or direction change.
// - type select 0 gives xor checksum, 1 gives crc-8 checksum.
// - xor mode: new checksum is data byte xor previous checksum.
// - crc mode: fold byte with polynomial x^8+x^5+x^4+1 into checksum.
// - checksum clears when register select bits or direction bit change.
// - status read command returns the accumulated checksum value.
`ifndef RTCS_CFG_SVH
`define RTCS_CFG_SVH
`define RTCS_CRC_POLY  8'h31
`define RTCS_SUM_RESET 8'h00
`define RTCS_MSB       7
`define RTCS_TYPE_XOR  1'b0
`define RTCS_TYPE_CRC  1'b1
`define RTCS_BYTE_BITS 8
`define RTCS_CRC_PROBE 8'h01
`define RTCS_SEL_RESET 2'h0
`define RTCS_DIR_RESET 1'b0
`define RTCS_VALID_OFF 1'b0
`define RTCS_VALID_ON  1'b1
`endif

// ### verilog/rtcs_pkg.sv
// types for the ram transfer checksum block
package rtcs_pkg;
    typedef logic [7:0] rtcs_byte_t;
    typedef logic [1:0] rtcs_sel_t;
endpackage

// ### verilog/rtcs_crc8_step.sv
// one-byte crc-8 step, msb first
`timescale 1ns/1ps
`default_nettype none
`include "rtcs_cfg.svh"
module rtcs_crc8_step
    import rtcs_pkg::*;
(
    // operands
    input  wire rtcs_byte_t crc_in,
    input  wire rtcs_byte_t data_in,
    // result
    output var rtcs_byte_t  crc_out
);
    always_comb begin
        rtcs_byte_t c;
        c = crc_in ^ data_in;
        for (int i = 0; i < `RTCS_BYTE_BITS; i++) begin
            if (c[`RTCS_MSB]) begin
                c = {c[6:0], 1'b0} ^ `RTCS_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        crc_out = c;
    end
endmodule // rtcs_crc8_step
`default_nettype wire

// ### verilog/rtcs_checksum.sv
// ram transfer checksum accumulator with status capture
`timescale 1ns/1ps
`default_nettype none
`include "rtcs_cfg.svh"
module rtcs_checksum
    import rtcs_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // checksum mode
    input  wire logic       checksum_type_select,
    // command select
    input  wire rtcs_sel_t  register_select_bits,
    input  wire logic       read_not_write,
    // data writes
    input  wire logic       data_write_stb,
    input  wire rtcs_byte_t data_byte,
    // status reads
    input  wire logic       status_read_stb,
    // result
    output var rtcs_byte_t  checksum,
    output var rtcs_byte_t  status_data,
    output var logic        status_valid
);

    // accumulator
    rtcs_byte_t sum_ff;
    rtcs_byte_t nxt_sum;

    // remembered command select and direction
    rtcs_sel_t  sel_ff;
    rtcs_sel_t  nxt_sel;
    logic       dir_ff;
    logic       nxt_dir;

    // captured status
    rtcs_byte_t stat_ff;
    rtcs_byte_t nxt_stat;
    logic       sv_ff;
    logic       nxt_sv;

    // candidate next values for each mode
    rtcs_byte_t crc_val;
    rtcs_byte_t xor_val;
    logic       sel_change;

    // one crc step per written byte, folded into the running value
    rtcs_crc8_step u_step (
        .crc_in  (sum_ff),
        .data_in (data_byte),
        .crc_out (crc_val)
    );

    assign xor_val = sum_ff ^ data_byte;

    // a change of select bits or direction against the last enabled cycle
    assign sel_change = (register_select_bits != sel_ff) || (read_not_write != dir_ff);

    // selection group: follows the command select every enabled cycle
    always_comb begin
        nxt_sel = register_select_bits;
        nxt_dir = read_not_write;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sel_ff <= `RTCS_SEL_RESET;
            dir_ff <= `RTCS_DIR_RESET;
        end else if (clk_en) begin
            sel_ff <= nxt_sel;
            dir_ff <= nxt_dir;
        end
    end

    // accumulator group: a clear wins over a write in the same cycle
    always_comb begin
        nxt_sum = sum_ff;
        if (sel_change) begin
            nxt_sum = `RTCS_SUM_RESET;
        end else if (data_write_stb) begin
            if (checksum_type_select == `RTCS_TYPE_CRC) begin
                nxt_sum = crc_val;
            end else begin
                nxt_sum = xor_val;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sum_ff <= `RTCS_SUM_RESET;
        end else if (clk_en) begin
            sum_ff <= nxt_sum;
        end
    end

    // status group: captures the value before any same-cycle write
    always_comb begin
        nxt_stat = stat_ff;
        nxt_sv   = `RTCS_VALID_OFF;
        if (status_read_stb) begin
            nxt_stat = sum_ff;
            nxt_sv   = `RTCS_VALID_ON;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stat_ff <= `RTCS_SUM_RESET;
            sv_ff   <= `RTCS_VALID_OFF;
        end else if (clk_en) begin
            stat_ff <= nxt_stat;
            sv_ff   <= nxt_sv;
        end
    end

    // outputs straight from flip-flops
    assign checksum     = sum_ff;
    assign status_data  = stat_ff;
    assign status_valid = sv_ff;

    // steps of each behaviour
    sequence s_clear;
        clk_en && sel_change;
    endsequence

    sequence s_clear_write;
        clk_en && sel_change && data_write_stb;
    endsequence

    sequence s_xor_write;
        clk_en && !sel_change && data_write_stb && (checksum_type_select == `RTCS_TYPE_XOR);
    endsequence

    sequence s_crc_write;
        clk_en && !sel_change && data_write_stb && (checksum_type_select == `RTCS_TYPE_CRC);
    endsequence

    sequence s_idle;
        clk_en && !sel_change && !data_write_stb;
    endsequence

    sequence s_status_read;
        clk_en && status_read_stb;
    endsequence

    sequence s_no_status;
        clk_en && !status_read_stb;
    endsequence

    sequence s_frozen;
        !clk_en;
    endsequence

    AST_CLEAR: assert property (@(posedge ref_clk) disable iff (rst)
        s_clear |=> sum_ff == `RTCS_SUM_RESET)
        else $error("checksum not cleared after select change");

    AST_CLEAR_WINS: assert property (@(posedge ref_clk) disable iff (rst)
        s_clear_write |=> sum_ff == `RTCS_SUM_RESET)
        else $error("write not dropped during select change");

    AST_SEL_TRACK: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en |=> sel_ff == $past(register_select_bits) && dir_ff == $past(read_not_write))
        else $error("select memory not following the command select");

    AST_XOR: assert property (@(posedge ref_clk) disable iff (rst)
        s_xor_write |=> sum_ff == ($past(sum_ff) ^ $past(data_byte)))
        else $error("xor checksum step wrong");

    AST_CRC: assert property (@(posedge ref_clk) disable iff (rst)
        s_crc_write |=> sum_ff == $past(crc_val))
        else $error("crc checksum step wrong");

    AST_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        s_idle |=> $stable(sum_ff))
        else $error("checksum changed without a write");

    AST_STAT: assert property (@(posedge ref_clk) disable iff (rst)
        s_status_read |=> status_valid && status_data == $past(sum_ff))
        else $error("status read returned wrong value");

    AST_STAT_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
        s_no_status |=> !status_valid)
        else $error("status valid held without a read");

    AST_STAT_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
        s_no_status |=> $stable(status_data))
        else $error("status data changed without a read");

    AST_CRC_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
        sum_ff == `RTCS_SUM_RESET && data_byte == `RTCS_SUM_RESET |-> crc_val == `RTCS_SUM_RESET)
        else $error("crc of zero byte from zero not zero");

    AST_CRC_ONE: assert property (@(posedge ref_clk) disable iff (rst)
        sum_ff == `RTCS_SUM_RESET && data_byte == `RTCS_CRC_PROBE |-> crc_val == `RTCS_CRC_POLY)
        else $error("crc polynomial wrong");

    AST_FREEZE: assert property (@(posedge ref_clk) disable iff (rst)
        s_frozen |=> $stable(sum_ff) && $stable(stat_ff) && $stable(sv_ff)
            && $stable(sel_ff) && $stable(dir_ff))
        else $error("state moved while clock enable low");

endmodule // rtcs_checksum
`default_nettype wire

// ### bench/rtcs_host.sv
// host model issuing command cycles
`timescale 1ns/1ps
`default_nettype none
module rtcs_host
    import rtcs_pkg::*;
(
    // command lines
    input  wire logic  ref_clk,
    output logic       ts,
    output rtcs_sel_t  sel,
    output logic       rnw,
    output logic       ws,
    output rtcs_byte_t wd,
    output logic       rs
);
    initial {ts, sel, rnw, ws, wd, rs} = '0;
    task automatic put(input logic t, rtcs_sel_t s, logic r, logic w, rtcs_byte_t d, logic q);
        @(posedge ref_clk) #1;
        {ts, sel, rnw, ws, wd, rs} = {t, s, r, w, d, q};
    endtask
endmodule // rtcs_host
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the checksum block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rtcs_pkg::*;
    logic ref_clk, rst, clk_en, ts, rnw, ws, rs, sv;
    rtcs_sel_t  sel;
    rtcs_byte_t wd, cs, sd;
    int err_count = 0, checks = 0, cyc = 0;
    rtcs_host host_u (.ref_clk(ref_clk), .ts(ts), .sel(sel), .rnw(rnw), .ws(ws), .wd(wd), .rs(rs));
    rtcs_checksum dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .checksum_type_select(ts), .register_select_bits(sel), .read_not_write(rnw),
        .data_write_stb(ws), .data_byte(wd), .status_read_stb(rs),
        .checksum(cs), .status_data(sd), .status_valid(sv));
    task automatic cmp(input string n, input rtcs_byte_t e, input rtcs_byte_t g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    function automatic rtcs_byte_t crc(input rtcs_byte_t c, input rtcs_byte_t d);
        c = c ^ d;
        repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
        return c;
    endfunction
    // back to back writes, status read, then a clear that drops a write
    task automatic t_mode(input logic t);
        rtcs_byte_t e, d;
        e = 8'h00;
        host_u.put(t, 2'h1, 1'b0, 1'b0, 8'h00, 1'b0);
        for (int i = 0; i < 3; i++) begin
            d = rtcs_byte_t'(8'h5a + 8'h55 * i);
            host_u.put(t, 2'h1, 1'b0, 1'b1, d, 1'b0);
            e = t ? crc(e, d) : e ^ d;
        end
        host_u.put(t, 2'h1, 1'b0, 1'b0, 8'h00, 1'b1);
        host_u.put(t, 2'h1, 1'b0, 1'b0, 8'h00, 1'b0);
        cmp("checksum", e, cs);
        cmp("status_data", e, sd);
        cmp("status_valid", 8'h01, {7'h00, sv});
        host_u.put(t, 2'h1, 1'b1, 1'b1, 8'h77, 1'b0);
        host_u.put(t, 2'h1, 1'b1, 1'b0, 8'h00, 1'b0);
        cmp("cleared", 8'h00, cs);
    endtask
    // clock enable low freezes a write, a select change and a status read
    task automatic t_freeze();
        rtcs_byte_t e;
        e = crc(8'h00, 8'h01);
        host_u.put(1'b1, 2'h1, 1'b0, 1'b0, 8'h00, 1'b0);
        host_u.put(1'b1, 2'h1, 1'b0, 1'b1, 8'h01, 1'b0);
        host_u.put(1'b1, 2'h2, 1'b0, 1'b1, 8'h55, 1'b1);
        clk_en = 1'b0;
        host_u.put(1'b1, 2'h1, 1'b0, 1'b0, 8'h00, 1'b0);
        cmp("frozen", e, cs);
        cmp("frozen_valid", 8'h00, {7'h00, sv});
        clk_en = 1'b1;
    endtask
    // reset in mid run clears the accumulator and the captured status
    task automatic t_reset();
        host_u.put(1'b1, 2'h1, 1'b0, 1'b1, 8'h10, 1'b1);
        host_u.put(1'b1, 2'h1, 1'b0, 1'b0, 8'h00, 1'b0);
        cmp("pre_reset", crc(crc(8'h00, 8'h01), 8'h10), cs);
        cmp("status_before_write", crc(8'h00, 8'h01), sd);
        rst = 1'b1;
        @(posedge ref_clk) #1;
        cmp("reset_sum", 8'h00, cs);
        cmp("reset_status", 8'h00, sd);
        rst = 1'b0;
        @(posedge ref_clk) #1;
        cmp("after_reset", 8'h00, cs);
    endtask
    task automatic results();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (++cyc > 2000) begin
        err_count++;
        results();
    end
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        repeat (20) @(posedge ref_clk);
        #1 rst = 1'b0;
        cmp("reset", 8'h00, cs);
        t_mode(1'b0);
        t_mode(1'b1);
        t_freeze();
        t_reset();
        results();
    end
endmodule // tb_top
`default_nettype wire
